// ==== hdl/disk_command_sequencer.sv ====
`timescale 1ns/1ps
`include "disk_seq_params.svh"
// Overview of operation
// - Status word: heads loaded 4, lid ajar 5, surface 6, model 7, multi-select 8.
// - Volume changed bit 9 sets on entering load heads; counts as drive error.
// - Bit 10 gate fault, bit 11 spindle fault, bit 12 positioning timeout.
// - Bit 13 write protect, bit 14 stray current, bit 15 missing write pulses.
// - Function code 0..7 selects maintenance through read without header check.
// - Commands need controller idle; software cannot set it; writes blocked when busy.
// - Error bits 10 to 13 clear whenever a new command starts.
// - Controller idle sets at command completion and on header missing, bad count or bus errors; overrun and compare errors do not end the command.
// - Write check matches header, then compares 128 words; mismatch sets bit 11.
// - Partial sectors are padded with all-zero words.
// - Get status runs without unit ready and pushes the status word to FIFO.
// - Seek shifts the location register serially out to the drive.
// - Read header pushes header word, zero word, header CRC into the FIFO.
// - Write fills FIFO by DMA, matches header, writes consecutive sectors.
// - Address and count step per word; sector field steps per sector.
// - At transfer end set idle; interrupt only when interrupt allow is set.
// - Read starts DMA with four words queued; stops at count overflow.
// - Read without header check within 300 us of last header; sector advances.
// - Maintenance needs count 9FC1 hex, else header missing; six tests step location.
// - Maintenance DMAs 256 words in, returns 255 to the next locations.
module disk_command_sequencer #(
  parameter int RNH_CYCLES = `RNH_CYC,
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = 256,
  parameter logic DRIVE_MODEL = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory DMA master
  output logic dma_req,
  output logic dma_we,
  output logic [15:0] dma_addr,
  output logic [15:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata,
  input wire logic dma_err,
  output logic irq_req,
  // Drive serial command link
  output logic ser_cmd_bit,
  output logic ser_cmd_en,
  // Drive data words
  input wire logic hdr_valid,
  input wire logic [15:0] hdr_word,
  input wire logic [15:0] hdr_crc,
  input wire logic hdr_crc_ok,
  input wire logic dat_valid,
  input wire logic [15:0] dat_word,
  input wire logic dat_crc_ok,
  output logic wr_gate,
  output logic [15:0] wr_word,
  input wire logic wr_ready,
  // Drive sense lines
  input wire logic unit_ready,
  input wire logic [2:0] drive_state,
  input wire logic brush_home,
  input wire logic heads_loaded_flag,
  input wire logic lid_ajar_flag,
  input wire logic multi_unit_select_fault,
  input wire logic spindle_fault,
  input wire logic positioning_timeout,
  input wire logic protect_flag,
  input wire logic sector_pulse,
  input wire logic write_current,
  input wire logic write_pulse
);
  // ----------------------------------------------
  // State
  // ----------------------------------------------
  disk_seq_pkg::seq_state_t st_r;
  disk_seq_pkg::func_code_t fn_r;
  logic [15:0] fifo_mem [0:FIFO_DEPTH-1];
  logic [7:0] wp_r, rp_r;
  logic [8:0] fcnt_r, seq_r;
  logic [15:0] bar_r, dar_r, count_r, age_r;
  logic [6:0] tries_r;
  logic [7:0] wde_cnt_r;
  logic idle_r, ie_r, e10_r, e11_r, e12_r, e13_r;
  logic vc_r, wge_r, hce_r, wde_r, surf_r;
  logic [2:0] dstate_r;
  logic aw_got_r, w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;

  // Sixteen-bit CRC used by the maintenance data path test
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ----------------------------------------------
  // Decode
  // ----------------------------------------------
  wire rd_cmd = (fn_r == disk_seq_pkg::FN_READ) |
                (fn_r == disk_seq_pkg::FN_RNH);
  wire wr_cmd = (fn_r == disk_seq_pkg::FN_WRITE);
  wire cnt_zero = (count_r == 16'h0000);
  wire fifo_empty = (fcnt_r == 9'h000);
  wire last_word = (seq_r == `SEC_WORDS - 9'h001);
  wire [15:0] head_word = fifo_empty ? 16'h0000 : fifo_mem[rp_r];
  wire hdr_match = hdr_valid & hdr_crc_ok & (hdr_word == dar_r);
  wire [15:0] dsw = {wde_r, hce_r, protect_flag, positioning_timeout,
                     spindle_fault, wge_r, vc_r, multi_unit_select_fault,
                     DRIVE_MODEL, surf_r, lid_ajar_flag, heads_loaded_flag,
                     brush_home, drive_state};
  wire drv_err = lid_ajar_flag | multi_unit_select_fault | vc_r |
                 wge_r | spindle_fault | positioning_timeout |
                 hce_r | wde_r;
  wire [15:0] command_status_reg = {e10_r | e11_r | e12_r | e13_r | drv_err, drv_err,
                     e13_r, e12_r, e11_r, e10_r, 2'b00, idle_r, ie_r,
                     2'b00, fn_r, unit_ready};

  // Bus slave handshakes; one write and one read in flight at most
  wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire sel_csr = (awaddr_r == `OFS_CSR);
  wire sel_bar = (awaddr_r == `OFS_BAR);
  wire sel_dar = (awaddr_r == `OFS_DAR);
  wire sel_mpr = (awaddr_r == `OFS_MPR);
  wire wr_hit = sel_csr | sel_bar | sel_dar | sel_mpr;
  wire wr_ok = wr_fire & idle_r & s_axi_wstrb[0];
  wire start = wr_ok & sel_csr & ~wdata_r[`CSR_IDLE];
  wire [2:0] new_fn = wdata_r[`CSR_FN_HI:`CSR_FN_LO];
  wire rd_mpr = rd_fire & (s_axi_araddr == `OFS_MPR);
  assign s_axi_awready = ~aw_got_r;
  assign s_axi_wready = ~w_got_r;
  assign s_axi_arready = ~s_axi_rvalid;

  // Transfer engine requests
  wire in_xfer = (st_r == disk_seq_pkg::S_XFER);
  wire fill_req = ((st_r == disk_seq_pkg::S_FILL) & ~cnt_zero &
                   (seq_r < `SEC_WORDS)) |
                  ((st_r == disk_seq_pkg::S_MFILL) &
                   (seq_r < `MAINT_FILL));
  wire rd_phase = (st_r == disk_seq_pkg::S_HDR) | in_xfer;
  wire drain_req = (rd_cmd & rd_phase & (fcnt_r >= `READ_START)) |
                   ((st_r == disk_seq_pkg::S_DRAIN) & ~fifo_empty) |
                   ((st_r == disk_seq_pkg::S_MRET) &
                    (seq_r < `MAINT_RET));
  assign dma_req = fill_req | drain_req;
  assign dma_we = drain_req;
  assign dma_addr = bar_r;
  assign dma_wdata = fifo_mem[rp_r];
  wire dma_done = dma_req & dma_ack;

  // Drive write path pads empty FIFO slots with zero words
  assign wr_gate = in_xfer & wr_cmd;
  assign wr_word = head_word;
  wire wr_take = wr_gate & wr_ready;
  wire chk_take = in_xfer & (fn_r == disk_seq_pkg::FN_WCHK) & dat_valid;
  wire rd_take = in_xfer & rd_cmd & dat_valid;
  wire word_step = wr_take | chk_take | rd_take;

  // FIFO push sources are exclusive by state
  logic push;
  logic [15:0] push_d;
  wire pop = (rd_mpr & idle_r & ~fifo_empty) | (dma_done & drain_req) |
             ((wr_take | chk_take) & ~fifo_empty);
  always_comb begin
    push = 1'b0;
    push_d = 16'h0000;
    if (dma_done & fill_req) begin
      push = 1'b1;
      push_d = dma_rdata;
    end else if (rd_take & ~cnt_zero) begin
      push = 1'b1;
      push_d = dat_word;
    end else if ((st_r == disk_seq_pkg::S_RDHDR) &
                 (hdr_valid | seq_r != 9'h000)) begin
      push = 1'b1;
      push_d = (seq_r == 9'h000) ? hdr_word :
               (seq_r == 9'h001) ? 16'h0000 : hdr_crc;
    end else if ((st_r == disk_seq_pkg::S_SHIFT) &
                 (seq_r == `SHIFT_BITS) &
                 (fn_r == disk_seq_pkg::FN_STAT)) begin
      push = 1'b1;
      push_d = dsw;
    end else if ((st_r == disk_seq_pkg::S_MTEST) & (seq_r == 9'h003)) begin
      push = 1'b1;
      push_d = crc16(dar_r);
    end else if ((st_r == disk_seq_pkg::S_MTEST) & (seq_r == 9'h004)) begin
      push = 1'b1;
      push_d = crc16(crc16(dar_r));
    end
  end

  // A push into a full FIFO means the bus fell behind the disk
  wire overrun = push & (fcnt_r == `FIFO_FULL);
  assign ser_cmd_bit = dar_r[seq_r[3:0]];
  assign ser_cmd_en = (st_r == disk_seq_pkg::S_SHIFT) &
                      (seq_r < `SHIFT_BITS);
  wire rnh_late = (age_r >= 16'(RNH_CYCLES));

  // ----------------------------------------------
  // Bus slave registers
  // ----------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & ~aw_got_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_got_r) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b11;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // OFS_MPR read pops the FIFO while idle; an empty FIFO reads as zero
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_CSR: s_axi_rdata <= {16'h0000, command_status_reg};
          `OFS_BAR: s_axi_rdata <= {16'h0000, bar_r};
          `OFS_DAR: s_axi_rdata <= {16'h0000, dar_r};
          `OFS_MPR: s_axi_rdata <= {16'h0000, idle_r ? head_word : 16'h0000};
          `OFS_DSW: s_axi_rdata <= {16'h0000, dsw};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b11;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------
  // FIFO
  // ----------------------------------------------
  always_ff @(posedge aclk) begin
    if (push & ~overrun) begin
      fifo_mem[wp_r] <= push_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      wp_r <= 8'h00;
      rp_r <= 8'h00;
      fcnt_r <= 9'h000;
    end else begin
      if (push & ~overrun) wp_r <= wp_r + 8'h01;
      if (pop) rp_r <= rp_r + 8'h01;
      fcnt_r <= fcnt_r + {8'h00, push & ~overrun} - {8'h00, pop};
    end
  end

  // ----------------------------------------------
  // Drive status tracking
  // ----------------------------------------------
  // Soft errors clear as a get status with reset begins, set wins
  wire soft_clr = (st_r == disk_seq_pkg::S_SHIFT) &
                  (seq_r == 9'h000) &
                  (fn_r == disk_seq_pkg::FN_STAT) & dar_r[`DAR_RST];
  wire vc_set = (drive_state == `LOAD_HEADS) &
                (dstate_r != `LOAD_HEADS);
  wire wge_set = wr_gate & (~unit_ready | sector_pulse | protect_flag);
  wire hce_set = write_current & ~wr_gate;
  wire wde_set = (wde_cnt_r == `WDE_CYC);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dstate_r <= 3'h0;
      vc_r <= 1'b0;
      wge_r <= 1'b0;
      hce_r <= 1'b0;
      wde_r <= 1'b0;
      wde_cnt_r <= 8'h00;
    end else begin
      dstate_r <= drive_state;
      vc_r <= vc_set | (vc_r & ~soft_clr);
      wge_r <= wge_set | (wge_r & ~soft_clr);
      hce_r <= hce_set | (hce_r & ~soft_clr);
      wde_r <= wde_set | (wde_r & ~soft_clr);
      if (!wr_gate || write_pulse) wde_cnt_r <= 8'h00;
      else if (!wde_set) wde_cnt_r <= wde_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------
  // Command sequencer
  // ----------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= disk_seq_pkg::S_IDLE;
      fn_r <= disk_seq_pkg::FN_MAINT;
      idle_r <= 1'b1;
      ie_r <= 1'b0;
      {e10_r, e11_r, e12_r, e13_r} <= 4'h0;
      irq_req <= 1'b0;
      bar_r <= 16'h0000;
      dar_r <= 16'h0000;
      count_r <= 16'h0000;
      seq_r <= 9'h000;
      tries_r <= 7'h00;
      age_r <= 16'h0000;
      surf_r <= 1'b0;
    end else begin
      // Age since the last header, saturating
      if (hdr_valid) age_r <= 16'h0000;
      else if (!rnh_late) age_r <= age_r + 16'h0001;
      if (overrun) e12_r <= 1'b1;
      if (dma_done) begin
        bar_r <= bar_r + 16'h0001;
        if (st_r == disk_seq_pkg::S_FILL) count_r <= count_r + 16'h0001;
      end
      if (rd_take & ~cnt_zero) count_r <= count_r + 16'h0001;
      if (wr_take | chk_take) seq_r <= seq_r + 9'h001;
      if (rd_take) seq_r <= seq_r + 9'h001;
      if (wr_ok & sel_bar) bar_r <= wdata_r[15:0];
      if (wr_ok & sel_dar) dar_r <= wdata_r[15:0];
      if (wr_ok & sel_mpr) count_r <= wdata_r[15:0];
      if (wr_ok & sel_csr) begin
        ie_r <= wdata_r[`CSR_IE];
        irq_req <= 1'b0;
      end
      if (start) begin
        fn_r <= disk_seq_pkg::func_code_t'(new_fn);
        idle_r <= 1'b0;
        {e10_r, e11_r, e12_r, e13_r} <= 4'h0;
        seq_r <= 9'h000;
        tries_r <= 7'h00;
      end
      case (st_r)
        disk_seq_pkg::S_IDLE: begin
          if (start) begin
            case (new_fn)
              disk_seq_pkg::FN_MAINT: begin
                if (count_r != `MAINT_COUNT) begin
                  {e10_r, e12_r} <= 2'b11;
                  st_r <= disk_seq_pkg::S_DONE;
                end else st_r <= disk_seq_pkg::S_MFILL;
              end
              disk_seq_pkg::FN_WCHK,
              disk_seq_pkg::FN_WRITE: st_r <= disk_seq_pkg::S_FILL;
              disk_seq_pkg::FN_STAT,
              disk_seq_pkg::FN_SEEK: st_r <= disk_seq_pkg::S_SHIFT;
              disk_seq_pkg::FN_RHDR: st_r <= disk_seq_pkg::S_RDHDR;
              disk_seq_pkg::FN_READ: st_r <= disk_seq_pkg::S_HDR;
              default: begin
                // Too late after the preceding header
                if (rnh_late) begin
                  e10_r <= 1'b1;
                  st_r <= disk_seq_pkg::S_DONE;
                end else st_r <= disk_seq_pkg::S_XFER;
              end
            endcase
          end
        end
        disk_seq_pkg::S_SHIFT: begin
          seq_r <= seq_r + 9'h001;
          if (seq_r == `SHIFT_BITS) begin
            if (fn_r == disk_seq_pkg::FN_SEEK) surf_r <= dar_r[4];
            st_r <= disk_seq_pkg::S_DONE;
          end
        end
        disk_seq_pkg::S_RDHDR: begin
          if (push) seq_r <= seq_r + 9'h001;
          if (seq_r == `HDR_WORDS - 9'h001) st_r <= disk_seq_pkg::S_DONE;
        end
        disk_seq_pkg::S_FILL: begin
          if (dma_done) seq_r <= seq_r + 9'h001;
          if (!fill_req) begin
            seq_r <= 9'h000;
            tries_r <= 7'h00;
            st_r <= disk_seq_pkg::S_HDR;
          end
        end
        disk_seq_pkg::S_HDR: begin
          if (hdr_match) begin
            seq_r <= 9'h000;
            st_r <= disk_seq_pkg::S_XFER;
          end else if (hdr_valid) begin
            tries_r <= tries_r + 7'h01;
            if (tries_r == `HDR_TRIES) begin
              {e10_r, e12_r} <= 2'b11;
              st_r <= disk_seq_pkg::S_DONE;
            end
          end
        end
        disk_seq_pkg::S_XFER: begin
          if (chk_take && dat_word != head_word) e11_r <= 1'b1;
          if (word_step && last_word) begin
            seq_r <= 9'h000;
            dar_r[5:0] <= dar_r[5:0] + 6'h01;
            if (!wr_cmd && !dat_crc_ok) e11_r <= 1'b1;
            if (cnt_zero && !(rd_take && count_r == 16'hFFFF)) begin
              st_r <= rd_cmd ? disk_seq_pkg::S_DRAIN :
                      disk_seq_pkg::S_DONE;
            end else if (fn_r == disk_seq_pkg::FN_RNH) begin
              st_r <= disk_seq_pkg::S_XFER;
            end else if (rd_cmd) begin
              st_r <= disk_seq_pkg::S_HDR;
            end else begin
              st_r <= disk_seq_pkg::S_FILL;
            end
          end
        end
        disk_seq_pkg::S_DRAIN: begin
          if (fifo_empty) st_r <= disk_seq_pkg::S_DONE;
        end
        disk_seq_pkg::S_MFILL: begin
          if (dma_done) seq_r <= seq_r + 9'h001;
          if (seq_r == `MAINT_FILL) begin
            seq_r <= 9'h000;
            st_r <= disk_seq_pkg::S_MRET;
          end
        end
        disk_seq_pkg::S_MRET: begin
          if (dma_done) seq_r <= seq_r + 9'h001;
          if (seq_r == `MAINT_RET) begin
            seq_r <= 9'h000;
            st_r <= disk_seq_pkg::S_MTEST;
          end
        end
        disk_seq_pkg::S_MTEST: begin
          // Low byte only: the high byte never takes a carry
          dar_r[7:0] <= dar_r[7:0] + 8'h01;
          seq_r <= seq_r + 9'h001;
          if (seq_r == `MAINT_TESTS - 9'h001) st_r <= disk_seq_pkg::S_DONE;
        end
        disk_seq_pkg::S_DONE: begin
          idle_r <= 1'b1;
          irq_req <= ie_r;
          st_r <= disk_seq_pkg::S_IDLE;
        end
        default: st_r <= disk_seq_pkg::S_IDLE;
      endcase
      // A bus error aborts any transfer at once
      if (dma_done && dma_err) begin
        e13_r <= 1'b1;
        st_r <= disk_seq_pkg::S_DONE;
      end
    end
  end
endmodule

// ==== hdl/disk_seq_params.svh ====
`ifndef DISK_SEQ_PARAMS_SVH
`define DISK_SEQ_PARAMS_SVH
// ----------------------------------------------
// Register byte offsets
// ----------------------------------------------
`define OFS_CSR 8'h00
`define OFS_BAR 8'h04
`define OFS_DAR 8'h08
`define OFS_MPR 8'h0C
`define OFS_DSW 8'h10
// ----------------------------------------------
// Command/status field positions
// ----------------------------------------------
`define CSR_RDY 0
`define CSR_FN_LO 1
`define CSR_FN_HI 3
`define CSR_IE 6
`define CSR_IDLE 7
`define CSR_E10 10
`define CSR_E11 11
`define CSR_E12 12
`define CSR_E13 13
`define CSR_DRV 14
`define CSR_ANY 15
`define DAR_RST 3
// ----------------------------------------------
// Counts and values
// ----------------------------------------------
`define SEC_WORDS 9'h080
`define READ_START 9'h004
`define FIFO_FULL 9'h100
`define MAINT_COUNT 16'h9FC1
`define MAINT_FILL 9'h100
`define MAINT_RET 9'h0FF
`define MAINT_TESTS 9'h006
`define SHIFT_BITS 9'h010
`define HDR_WORDS 9'h003
`define LOAD_HEADS 3'h3
`define HDR_TRIES 7'h50
`define WDE_CYC 8'h40
`define CRC_POLY 16'h8005
`define CLK_MHZ 125
`define RNH_US 300
`define RNH_CYC (`RNH_US * `CLK_MHZ)
`endif

// ==== hdl/disk_seq_pkg.sv ====
package disk_seq_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SHIFT = 4'h1, S_RDHDR = 4'h2, S_FILL = 4'h3,
    S_HDR = 4'h4, S_XFER = 4'h5, S_DRAIN = 4'h6, S_MFILL = 4'h7,
    S_MRET = 4'h8, S_MTEST = 4'h9, S_DONE = 4'hA
  } seq_state_t;
  typedef enum logic [2:0] {
    FN_MAINT = 3'h0, FN_WCHK = 3'h1, FN_STAT = 3'h2, FN_SEEK = 3'h3,
    FN_RHDR = 3'h4, FN_WRITE = 3'h5, FN_READ = 3'h6, FN_RNH = 3'h7
  } func_code_t;
endpackage

// ==== verification/disk_seq_props.sv ====
`timescale 1ns/1ps
module disk_seq_props #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // DMA and drive link
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic ser_cmd_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A read request taken this cycle
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  property p_rd_answer; rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write answer dropped");
  property p_unmapped;
    rd_take && s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'b11;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read accepted");
  // Sixteen bit times, then the enable drops
  property p_shift_len;
    $rose(ser_cmd_en) |-> ser_cmd_en [*8] ##1 ser_cmd_en [*8] ##1 !ser_cmd_en;
  endproperty
  a_shift_len: assert property (p_shift_len)
    else $error("seek shift length wrong");
  property p_dma_step;
    dma_req && dma_ack |=> dma_addr == $past(dma_addr) + 16'h0001;
  endproperty
  a_dma_step: assert property (p_dma_step)
    else $error("address not stepped");
  property p_dma_hold;
    dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_we);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("memory request changed early");
  property p_one_cmd; !(ser_cmd_en && dma_req); endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("two commands at once");
  c_read: cover property (rd_take);
  c_shift: cover property ($rose(ser_cmd_en));
  c_dma: cover property (dma_req && dma_ack);
endmodule
bind disk_command_sequencer disk_seq_props #(.ADDR_W(ADDR_W)) props_u (.*);

// ==== verification/drive_mem_model.sv ====
`timescale 1ns/1ps
module drive_mem_model (
  // Clock
  input wire logic aclk,
  // Memory side
  input wire logic dma_req,
  input wire logic [15:0] dma_addr,
  output logic dma_ack,
  output logic [15:0] dma_rdata,
  output logic dma_err,
  // Drive write side
  input wire logic wr_gate,
  output logic wr_ready
);
  logic [1:0] wait_r = 2'h0;
  logic slow_r = 1'b0;
  // Memory always exists; the drive takes a word each gated cycle
  assign dma_err = 1'b0;
  assign wr_ready = wr_gate;
  // Prompt and slow answers in turn; idle data toggles so none looks held
  always @(posedge aclk) begin
    dma_ack <= 1'b0;
    dma_rdata <= ~dma_rdata;
    if (dma_req && !dma_ack && wait_r != 2'h0) wait_r <= wait_r - 2'h1;
    if (dma_req && !dma_ack && wait_r == 2'h0) begin
      dma_ack <= 1'b1;
      dma_rdata <= dma_addr ^ 16'hA5A5;
      wait_r <= slow_r ? 2'h0 : 2'h3;
      slow_r <= ~slow_r;
    end
  end
endmodule

// ==== verification/disk_command_sequencer_bench.sv ====
`timescale 1ns/1ps
module disk_command_sequencer_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, unit_ready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dma_req, dma_we, dma_ack, dma_err, irq_req;
  logic ser_cmd_bit, ser_cmd_en, wr_gate, wr_ready, hdr_valid = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] dma_addr, dma_wdata, dma_rdata, wr_word, shift_r;
  logic [15:0] hdr_word = 16'h0000, sense = 16'h3935;
  int errors = 0, checked = 0, wr_n = 0, zero_n = 0, n;
  // Free-running clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  // Seek bits arrive low bit first; count words taken by the drive
  always @(posedge aclk) begin
    if (ser_cmd_en) shift_r <= {ser_cmd_bit, shift_r[15:1]};
    if (wr_gate && wr_ready) wr_n <= wr_n + 1;
    if (wr_gate && wr_ready && wr_word === 16'h0) zero_n <= zero_n + 1;
  end
  disk_command_sequencer #(.RNH_CYCLES(200)) dut_u (.*,
    .hdr_crc(~hdr_word), .hdr_crc_ok(hdr_valid), .dat_valid(1'b0),
    .dat_word(hdr_word), .dat_crc_ok(1'b1), .drive_state(sense[2:0]),
    .brush_home(sense[3]), .heads_loaded_flag(sense[4]),
    .lid_ajar_flag(sense[5]), .multi_unit_select_fault(sense[8]),
    .spindle_fault(sense[11]), .positioning_timeout(sense[12]),
    .protect_flag(sense[13]), .sector_pulse(1'b0),
    .write_current(1'b0), .write_pulse(wr_gate));
  drive_mem_model mem_u (.*);
  task automatic check(input logic [31:0] seen, want, input string what);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic give_up(input int k);
    if (k >= 60) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask
  // Polls the command register until the controller is idle
  task automatic idle_wait;
    int k;
    rd = 32'h0;
    for (k = 0; k < 400 && rd[7] !== 1'b1; k++) rd_reg(8'h00);
    give_up(k < 400 ? 0 : 60);
  endtask
  task automatic hdr_pulse(input logic [15:0] w);
    repeat (30) @(posedge aclk);
    hdr_word <= w;
    hdr_valid <= 1'b1;
    @(posedge aclk);
    hdr_valid <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset;
    rd_reg(8'h00);
    check(rd[15:0], 16'hC080, "csr after reset");
    rd_reg(8'h14);
    check(rr, 2'b11, "unmapped read");
    $display("reset test done");
  endtask
  task automatic t_status;
    sense <= 16'h3933;
    repeat (4) @(posedge aclk);
    sense <= 16'h3935;
    rd_reg(8'h10);
    check(rd[15:0] & 16'hFFBF, 16'h3B35, "live status");
    wr(8'h08, 32'h000B);
    wr(8'h00, 32'h0004);
    idle_wait();
    rd_reg(8'h0C);
    check(rd[15:0] & 16'hFFBF, 16'h3935, "status word");
    $display("status test done");
  endtask
  task automatic t_seek;
    wr(8'h08, 32'h0295);
    wr(8'h00, 32'h0006);
    idle_wait();
    check(shift_r, 16'h0295, "seek bits");
    $display("seek test done");
  endtask
  task automatic t_maint;
    wr(8'h0C, 32'hFFFF);
    wr(8'h00, 32'h0000);
    idle_wait();
    check(rd[13:10], 4'h5, "bad count");
    wr(8'h00, 32'h0006);
    idle_wait();
    check(rd[13:10], 4'h0, "errors cleared");
    $display("maintenance test done");
  endtask
  task automatic t_rhdr;
    unit_ready <= 1'b1;
    wr(8'h00, 32'h0008);
    hdr_pulse(16'h1C2A);
    idle_wait();
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'h0C);
      check(rd[15:0], i == 0 ? 16'h1C2A : i == 1 ? 16'h0 : 16'hE3D5,
        "header word");
    end
    $display("header test done");
  endtask
  task automatic t_write;
    wr(8'h04, 32'h0040);
    wr(8'h08, 32'h0105);
    wr(8'h0C, 32'hFFFF);
    wr(8'h00, 32'h004A);
    wr(8'h08, 32'h7777);
    hdr_pulse(16'h0105);
    idle_wait();
    check(irq_req, 1'b1, "irq");
    check(zero_n, 127, "pad words");
    check(wr_n, 128, "sector words");
    rd_reg(8'h04);
    check(rd[15:0], 16'h0041, "bus address");
    rd_reg(8'h08);
    check(rd[15:0], 16'h0106, "sector step");
    $display("write test done");
  endtask
  // Reset for sixteen cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_status();
    t_seek();
    t_maint();
    t_rhdr();
    t_write();
    print_verdict();
  end
endmodule
